// ===== core/bcx_pkg.sv
// Shared constants and carrier types for the branch and block copy execution unit.
package bcx_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int XW = 60;
  localparam int BW = 18;
  localparam int CW = 48;
  localparam int MAW = 21;
  localparam int EAW = 30;
  localparam int NW = 17;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  localparam logic [8:0] OP_COPY = 9'h009;
  localparam logic [8:0] OP_READ_CNT = 9'h00e;
  localparam logic [5:0] OP_CJUMP = 6'h02;
  localparam logic [8:0] OP_ZERO_BR = 9'h018;
  localparam logic [8:0] OP_PLUS_BR = 9'h01a;
  localparam logic [8:0] OP_DEF_BR = 9'h01e;
  localparam logic [8:0] OP_INDEF_BR = 9'h01f;
  localparam logic [8:0] OP_EQ_BR = 9'h021;

  // ----------------------------------------------------------------
  // Field positions and patterns
  // ----------------------------------------------------------------
  localparam int STD_ADDR_MSB = 22;
  localparam int EXP_ADDR_MSB = 28;
  localparam int STD_CHK_MSB = 23;
  localparam int EXP_CHK_MSB = 29;
  localparam int SRC_LSB = 30;
  localparam int SRC_MSB = 50;
  localparam int ZERO_XFER_BIT_A = 21;
  localparam int ZERO_XFER_BIT_B = 22;
  localparam int SIGN_BIT = 59;
  localparam int EXP_MSB = 59;
  localparam int EXP_LSB = 48;
  localparam logic [11:0] INDEF_POS = 12'h3ff;
  localparam logic [11:0] INDEF_NEG = 12'hc00;
  localparam logic [1:0] PARCEL_FIRST = 2'h0;
  localparam logic [CW-1:0] CNT_RESET = 48'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic blk_copy;
    logic expanded;
    logic ext_enable;
  } bcx_xflags_s;

  typedef struct packed {
    logic [29:0] word;
    logic [1:0] parcel;
  } bcx_issue_s;

  typedef struct packed {
    logic jump;
    logic flush;
    logic next_parcel2;
    logic next_word;
    logic [BW-1:0] target;
  } bcx_seq_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_FIN = 4'b1000
  } bcx_state_e;

endpackage

// ===== core/bcx_ones_add.sv
// Eighteen-bit one's complement adder with end-around carry.
`timescale 1ns/10ps
`default_nettype none
module bcx_ones_add (
  // Operands
  input wire logic [17:0] a,
  input wire logic [17:0] b,
  // Sum
  output logic [17:0] sum
);
  logic [18:0] raw;

  assign raw = {1'b0, a} + {1'b0, b};
  assign sum = raw[17:0] + {17'h0, raw[18]};
endmodule // bcx_ones_add
`default_nettype wire

// ===== core/bcx_run_counter.sv
// Free-running counter that the counter-read operation samples.
`timescale 1ns/10ps
`default_nettype none
module bcx_run_counter #(
  parameter int WIDTH = 48
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Count
  output logic [WIDTH-1:0] count
);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // bcx_run_counter
`default_nettype wire

// ===== core/bcx_exec_unit.sv
// Execution unit for block copy, counter read, computed jump and test branches.
//
// Notes on behaviour
// - Standard mode: bits 0-22 plus ext base.
// - Expanded mode: bits 0-28 plus ext base.
// - Source is alt or copy reg plus base.
// - Flag set: source from copy bits 30-50.
// - Word count is one's complement index plus immediate.
// - Zero count is pass; registers stay unchanged.
// - Bit 21/22 set: zeros, resume parcel 2.
// - Interrupted copy restarts from first word.
// - Illegal unless parcel 0 and enabled.
// - Standard check: 24 bits against 23-bit length.
// - Expanded check: 30 bits against 29-bit length.
// - Out of range when address reaches length.
// - Negative count takes range error exit.
// - Counter read: 48 bits, upper twelve zero.
// - Counter read legal in any parcel.
// - Two-parcel branches use low 18 bits.
// - Computed jump adds index i plus immediate.
// - Computed jump discards rest of word.
// - Zero branch on positive or negative zero.
// - Sign branch jumps when bit 59 clear.
// - Definite branch continues only on indefinite.
// - Indefinite branch jumps only on indefinite.
// - Equality branch jumps when indices identical.
`timescale 1ns/10ps
`default_nettype none
module bcx_exec_unit #(
  parameter int CNT_W = bcx_pkg::CW
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Instruction issue
  input wire logic ISSUE,
  input wire bcx_pkg::bcx_issue_s INSTR,
  input wire logic ABORT,
  output logic BUSY,
  // Operand values selected by the issue stage
  input wire logic [bcx_pkg::BW-1:0] INDEX_REG_I,
  input wire logic [bcx_pkg::BW-1:0] INDEX_REG_J,
  input wire logic [bcx_pkg::XW-1:0] OPERAND_REG_J,
  input wire logic [bcx_pkg::XW-1:0] COPY_ADDRESS_REG,
  input wire logic [bcx_pkg::BW-1:0] ALT_COPY_ADDRESS_REG,
  // Exchange package context
  input wire bcx_pkg::bcx_xflags_s XFLAGS,
  input wire logic [bcx_pkg::MAW-1:0] MAIN_BASE_ADDRESS,
  input wire logic [bcx_pkg::EAW-1:0] EXT_BASE_ADDRESS,
  input wire logic [bcx_pkg::EAW-1:0] EXT_FIELD_LENGTH,
  // Main memory read port
  output logic MAIN_RD_REQ,
  output logic [bcx_pkg::MAW-1:0] MAIN_RD_ADDR,
  input wire logic MAIN_RD_VALID,
  input wire logic [bcx_pkg::XW-1:0] MAIN_RD_DATA,
  // Bulk extended memory write port
  output logic EXT_WR_REQ,
  output logic [bcx_pkg::EAW-1:0] EXT_WR_ADDR,
  output logic [bcx_pkg::XW-1:0] EXT_WR_DATA,
  input wire logic EXT_WR_ACK,
  // Results
  output logic DONE,
  output bcx_pkg::bcx_seq_s SEQ,
  output logic WR_J,
  output logic [bcx_pkg::XW-1:0] WR_J_DATA,
  output logic ILLEGAL,
  output logic RANGE_ERR,
  output logic OUT_OF_RANGE
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [8:0] op9;
  logic [5:0] op6;
  logic [bcx_pkg::BW-1:0] imm;
  logic take;
  logic is_copy;
  logic is_rc;
  logic is_jp;
  logic is_zr;
  logic is_pl;
  logic is_df;
  logic is_id;
  logic is_eq;
  bcx_pkg::bcx_state_e state;
  bcx_pkg::bcx_state_e next_state;

  assign op9 = INSTR.word[29:21];
  assign op6 = INSTR.word[29:24];
  assign imm = INSTR.word[bcx_pkg::BW-1:0];
  assign take = ISSUE && (state == bcx_pkg::ST_IDLE);
  assign is_copy = (op9 == bcx_pkg::OP_COPY);
  assign is_rc = (op9 == bcx_pkg::OP_READ_CNT);
  assign is_jp = (op6 == bcx_pkg::OP_CJUMP);
  assign is_zr = (op9 == bcx_pkg::OP_ZERO_BR);
  assign is_pl = (op9 == bcx_pkg::OP_PLUS_BR);
  assign is_df = (op9 == bcx_pkg::OP_DEF_BR);
  assign is_id = (op9 == bcx_pkg::OP_INDEF_BR);
  assign is_eq = (op9 == bcx_pkg::OP_EQ_BR);

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  logic [bcx_pkg::BW-1:0] count_sum;
  logic [bcx_pkg::BW-1:0] jump_sum;
  logic [CNT_W-1:0] run_count;

  bcx_ones_add u_count_add (
    .a(INDEX_REG_J),
    .b(imm),
    .sum(count_sum)
  );

  bcx_ones_add u_jump_add (
    .a(INDEX_REG_I),
    .b(imm),
    .sum(jump_sum)
  );

  bcx_run_counter #(
    .WIDTH(CNT_W)
  ) u_counter (
    .clk(CLK),
    .arst_n(ARST_N),
    .count(run_count)
  );

  // ----------------------------------------------------------------
  // Block copy address formation and checks
  // ----------------------------------------------------------------
  logic count_zero;
  logic count_neg;
  logic [bcx_pkg::EAW-1:0] ext_off;
  logic [bcx_pkg::EAW-1:0] ext_start;
  logic [bcx_pkg::EAW-1:0] chk_addr;
  logic [bcx_pkg::EAW-1:0] chk_len;
  logic [bcx_pkg::MAW-1:0] src_off;
  logic [bcx_pkg::MAW-1:0] src_start;
  logic zero_xfer;
  logic copy_illegal;
  logic copy_oor;

  // Both zero encodings count as an empty block.
  assign count_zero = (count_sum == '0) || (&count_sum);
  assign count_neg = count_sum[bcx_pkg::BW-1] && !count_zero;

  always_comb begin
    if (XFLAGS.expanded) begin
      ext_off = {{(bcx_pkg::EAW-bcx_pkg::EXP_ADDR_MSB-1){1'b0}},
                 COPY_ADDRESS_REG[bcx_pkg::EXP_ADDR_MSB:0]};
      chk_addr = COPY_ADDRESS_REG[bcx_pkg::EXP_CHK_MSB:0];
      chk_len = {1'b0, EXT_FIELD_LENGTH[bcx_pkg::EXP_CHK_MSB-1:0]};
    end else begin
      ext_off = {{(bcx_pkg::EAW-bcx_pkg::STD_ADDR_MSB-1){1'b0}},
                 COPY_ADDRESS_REG[bcx_pkg::STD_ADDR_MSB:0]};
      chk_addr = {{(bcx_pkg::EAW-bcx_pkg::STD_CHK_MSB-1){1'b0}},
                  COPY_ADDRESS_REG[bcx_pkg::STD_CHK_MSB:0]};
      chk_len = {{(bcx_pkg::EAW-bcx_pkg::STD_CHK_MSB){1'b0}},
                 EXT_FIELD_LENGTH[bcx_pkg::STD_CHK_MSB-1:0]};
    end
  end

  assign ext_start = ext_off + EXT_BASE_ADDRESS;
  assign zero_xfer = ext_start[bcx_pkg::ZERO_XFER_BIT_A] || ext_start[bcx_pkg::ZERO_XFER_BIT_B];
  assign copy_oor = (chk_addr >= chk_len);

  // Copy register bits above the source field are not checked; software must clear them.
  always_comb begin
    if (XFLAGS.blk_copy) begin
      src_off = COPY_ADDRESS_REG[bcx_pkg::SRC_MSB:bcx_pkg::SRC_LSB];
    end else begin
      src_off = {{(bcx_pkg::MAW-bcx_pkg::BW){1'b0}}, ALT_COPY_ADDRESS_REG};
    end
  end

  assign src_start = src_off + MAIN_BASE_ADDRESS;
  assign copy_illegal = (INSTR.parcel != bcx_pkg::PARCEL_FIRST) || !XFLAGS.ext_enable;

  // ----------------------------------------------------------------
  // Branch decisions
  // ----------------------------------------------------------------
  logic [11:0] upper;
  logic indef;
  logic branch_taken;

  assign upper = OPERAND_REG_J[bcx_pkg::EXP_MSB:bcx_pkg::EXP_LSB];
  assign indef = (upper == bcx_pkg::INDEF_POS) || (upper == bcx_pkg::INDEF_NEG);

  always_comb begin
    branch_taken = 1'b0;
    if (is_zr) begin
      branch_taken = (OPERAND_REG_J == '0) || (&OPERAND_REG_J);
    end else if (is_pl) begin
      branch_taken = !OPERAND_REG_J[bcx_pkg::SIGN_BIT];
    end else if (is_df) begin
      branch_taken = !indef;
    end else if (is_id) begin
      branch_taken = indef;
    end else if (is_eq) begin
      branch_taken = (INDEX_REG_I == INDEX_REG_J);
    end
  end

  // ----------------------------------------------------------------
  // Copy state machine
  // ----------------------------------------------------------------
  logic start_copy;
  logic [bcx_pkg::NW-1:0] remain;
  logic zero_mode;
  logic last_word;

  assign start_copy = take && is_copy && !copy_illegal && !copy_oor && !count_neg && !count_zero;
  assign last_word = (remain == {{(bcx_pkg::NW-1){1'b0}}, 1'b1});

  always_comb begin
    next_state = state;
    unique case (state)
      bcx_pkg::ST_IDLE: begin
        if (start_copy) begin
          next_state = zero_xfer ? bcx_pkg::ST_WRITE : bcx_pkg::ST_READ;
        end
      end
      bcx_pkg::ST_READ: begin
        if (MAIN_RD_VALID) begin
          next_state = bcx_pkg::ST_WRITE;
        end
      end
      bcx_pkg::ST_WRITE: begin
        if (EXT_WR_ACK) begin
          if (last_word) begin
            next_state = bcx_pkg::ST_FIN;
          end else begin
            next_state = zero_mode ? bcx_pkg::ST_WRITE : bcx_pkg::ST_READ;
          end
        end
      end
      bcx_pkg::ST_FIN: begin
        next_state = bcx_pkg::ST_IDLE;
      end
    endcase
    // Nothing of a partial copy is kept, so a reissue starts over.
    if (ABORT) begin
      next_state = bcx_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= bcx_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Working copies of the addresses; the architectural registers are never written.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MAIN_RD_ADDR <= '0;
      EXT_WR_ADDR <= '0;
      remain <= '0;
      zero_mode <= 1'b0;
    end else if (start_copy) begin
      MAIN_RD_ADDR <= src_start;
      EXT_WR_ADDR <= ext_start;
      remain <= count_sum[bcx_pkg::NW-1:0];
      zero_mode <= zero_xfer;
    end else if (state == bcx_pkg::ST_WRITE && EXT_WR_ACK) begin
      MAIN_RD_ADDR <= MAIN_RD_ADDR + {{(bcx_pkg::MAW-1){1'b0}}, 1'b1};
      EXT_WR_ADDR <= EXT_WR_ADDR + {{(bcx_pkg::EAW-1){1'b0}}, 1'b1};
      remain <= remain - {{(bcx_pkg::NW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      EXT_WR_DATA <= '0;
    end else if (start_copy && zero_xfer) begin
      EXT_WR_DATA <= '0;
    end else if (state == bcx_pkg::ST_READ && MAIN_RD_VALID) begin
      EXT_WR_DATA <= MAIN_RD_DATA;
    end
  end

  assign MAIN_RD_REQ = (state == bcx_pkg::ST_READ);
  assign EXT_WR_REQ = (state == bcx_pkg::ST_WRITE);
  assign BUSY = (state != bcx_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // Completion, sequencing and error outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DONE <= 1'b0;
      SEQ <= '0;
      ILLEGAL <= 1'b0;
      RANGE_ERR <= 1'b0;
      OUT_OF_RANGE <= 1'b0;
    end else begin
      DONE <= 1'b0;
      SEQ <= '0;
      ILLEGAL <= 1'b0;
      RANGE_ERR <= 1'b0;
      OUT_OF_RANGE <= 1'b0;
      if (state == bcx_pkg::ST_FIN && !ABORT) begin
        DONE <= 1'b1;
        SEQ.next_parcel2 <= zero_mode;
        SEQ.next_word <= !zero_mode;
      end else if (take && is_copy) begin
        if (copy_illegal) begin
          DONE <= 1'b1;
          ILLEGAL <= 1'b1;
        end else if (copy_oor) begin
          DONE <= 1'b1;
          OUT_OF_RANGE <= 1'b1;
        end else if (count_neg) begin
          DONE <= 1'b1;
          RANGE_ERR <= 1'b1;
        end else if (count_zero) begin
          DONE <= 1'b1;
          SEQ.next_word <= 1'b1;
        end
      end else if (take && is_jp) begin
        DONE <= 1'b1;
        SEQ.jump <= 1'b1;
        SEQ.flush <= 1'b1;
        SEQ.target <= jump_sum;
      end else if (take && (is_zr || is_pl || is_df || is_id || is_eq)) begin
        DONE <= 1'b1;
        SEQ.jump <= branch_taken;
        SEQ.flush <= branch_taken;
        SEQ.target <= imm;
      end else if (take && is_rc) begin
        DONE <= 1'b1;
      end
    end
  end

  // Operand register j is written only by the counter read.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      WR_J <= 1'b0;
      WR_J_DATA <= '0;
    end else begin
      WR_J <= take && is_rc;
      if (take && is_rc) begin
        WR_J_DATA <= {{(bcx_pkg::XW-CNT_W){1'b0}}, run_count};
      end
    end
  end

endmodule // bcx_exec_unit
`default_nettype wire

// ===== dv/bcx_exec_assertions.sv
// Port-level assertions for the execution unit.
`timescale 1ns/10ps
`default_nettype none
module bcx_exec_assertions #(
  parameter int CNT_W = bcx_pkg::CW
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Issue and operands
  input wire logic ISSUE,
  input wire bcx_pkg::bcx_issue_s INSTR,
  input wire logic BUSY,
  input wire logic [bcx_pkg::BW-1:0] INDEX_REG_I,
  input wire logic [bcx_pkg::BW-1:0] INDEX_REG_J,
  input wire logic [bcx_pkg::XW-1:0] OPERAND_REG_J,
  input wire bcx_pkg::bcx_xflags_s XFLAGS,
  // Results
  input wire logic DONE,
  input wire bcx_pkg::bcx_seq_s SEQ,
  input wire logic WR_J,
  input wire logic [bcx_pkg::XW-1:0] WR_J_DATA,
  input wire logic ILLEGAL
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic tk;
  logic ind;
  logic [8:0] op;
  logic [18:0] s;
  assign tk = ISSUE && !BUSY;
  assign op = INSTR.word[29:21];
  assign ind = OPERAND_REG_J[59:48] == 12'h3ff || OPERAND_REG_J[59:48] == 12'hc00;
  // The end-around carry is folded in by the jump check below so the expected target is independent of the adder.
  assign s = {1'b0, INDEX_REG_I} + {1'b0, INSTR.word[17:0]};
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  upper_zero_a: assert property (WR_J |-> WR_J_DATA[59:48] == 12'h000) else $error("counter upper bits set");
  read_any_a: assert property (tk && op == 9'h00e |=> DONE && WR_J && !ILLEGAL) else $error("counter read refused");
  branch_target_a: assert property (tk && op inside {9'h018, 9'h01a, 9'h01e, 9'h01f, 9'h021}
    |=> DONE && SEQ.target == $past(INSTR.word[17:0])) else $error("branch target wrong");
  cjump_target_a: assert property (tk && INSTR.word[29:24] == 6'h02
    |=> SEQ.jump && SEQ.flush && SEQ.target == $past(s[17:0] + {17'h0, s[18]})) else $error("jump sum wrong");
  zero_branch_a: assert property (tk && op == 9'h018 |=> DONE
    && SEQ.jump == ($past(OPERAND_REG_J) == '0 || $past(OPERAND_REG_J) == '1)) else $error("zero test wrong");
  sign_branch_a: assert property (tk && op == 9'h01a
    |=> DONE && SEQ.jump == !$past(OPERAND_REG_J[59])) else $error("sign test wrong");
  def_branch_a: assert property (tk && op == 9'h01e |=> DONE && SEQ.jump == !$past(ind)) else $error("definite test wrong");
  indef_branch_a: assert property (tk && op == 9'h01f |=> DONE && SEQ.jump == $past(ind)) else $error("indefinite test wrong");
  eq_branch_a: assert property (tk && op == 9'h021
    |=> DONE && SEQ.jump == ($past(INDEX_REG_I) == $past(INDEX_REG_J))) else $error("equality test wrong");
  copy_illegal_a: assert property (tk && op == 9'h009 && (INSTR.parcel != 2'h0 || !XFLAGS.ext_enable)
    |=> DONE && ILLEGAL) else $error("illegal copy taken");
endmodule // bcx_exec_assertions
bind bcx_exec_unit bcx_exec_assertions #(.CNT_W(CNT_W)) u_chk (.CLK(CLK), .ARST_N(ARST_N), .ISSUE(ISSUE),
  .INSTR(INSTR), .BUSY(BUSY), .INDEX_REG_I(INDEX_REG_I), .INDEX_REG_J(INDEX_REG_J), .OPERAND_REG_J(OPERAND_REG_J),
  .XFLAGS(XFLAGS), .DONE(DONE), .SEQ(SEQ), .WR_J(WR_J), .WR_J_DATA(WR_J_DATA), .ILLEGAL(ILLEGAL));
`default_nettype wire

// ===== dv/bcx_mem_model.sv
// Behavioural main memory and bulk extended memory with adjustable latency.
`timescale 1ns/10ps
`default_nettype none
module bcx_mem_model (
  // Clock, reset and latency
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] dly,
  // Main memory read port
  input wire logic rd_req,
  input wire logic [bcx_pkg::MAW-1:0] rd_addr,
  output logic rd_valid,
  output logic [bcx_pkg::XW-1:0] rd_data,
  // Bulk extended memory write port
  input wire logic wr_req,
  input wire logic [bcx_pkg::EAW-1:0] wr_addr,
  input wire logic [bcx_pkg::XW-1:0] wr_data,
  output logic wr_ack
);
  // ------------------------------------------------------------
  // Memories
  // ------------------------------------------------------------
  logic [1:0] rc;
  logic [1:0] wc;
  logic [bcx_pkg::XW-1:0] pat;
  int n = 0;
  int nr = 0;
  logic [bcx_pkg::EAW-1:0] wa [64];
  logic [bcx_pkg::XW-1:0] wd [64];
  assign pat = {39'h5a5a5a5a5a, rd_addr};
  assign rd_valid = rd_req && rc >= dly;
  // Off a valid cycle the data lines show the inverse, so a stale word is never taken for fresh.
  assign rd_data = rd_valid ? pat : ~pat;
  assign wr_ack = wr_req && wc >= dly;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rc <= 2'h0;
      wc <= 2'h0;
    end else begin
      rc <= (rd_req && !rd_valid) ? rc + 2'h1 : 2'h0;
      wc <= (wr_req && !wr_ack) ? wc + 2'h1 : 2'h0;
      if (rd_valid) nr <= nr + 1;
      if (wr_ack) begin
        wa[n] <= wr_addr;
        wd[n] <= wr_data;
        n <= n + 1;
      end
    end
  end
endmodule // bcx_mem_model
`default_nettype wire

// ===== dv/tb_top.sv
// Directed testbench for the execution unit and its memory partner.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t got %h expected %h", $time, (a), (b)); end end
module tb_top;
  // ------------------------------------------------------------
  // Stimulus and checks
  // ------------------------------------------------------------
  logic clk, arst_n, issue, abort, busy, rd_req, rd_valid, wr_req, wr_ack, done, wj, ill, oor, rerr;
  logic [1:0] dly;
  logic [2:0] res;
  logic [17:0] bi, bj, xalt;
  logic [20:0] mba, rd_addr;
  logic [29:0] eba, efl, wr_addr;
  logic [59:0] xj, xa, rd_data, wr_data, wjd, c0;
  bcx_pkg::bcx_issue_s instr;
  bcx_pkg::bcx_xflags_s xf;
  bcx_pkg::bcx_seq_s seq, sq;
  int miscompares = 0;
  int samples_checked = 0;
  bcx_exec_unit #(.CNT_W(48)) DUT (.CLK(clk), .ARST_N(arst_n), .ISSUE(issue), .INSTR(instr), .ABORT(abort),
    .BUSY(busy), .INDEX_REG_I(bi), .INDEX_REG_J(bj), .OPERAND_REG_J(xj), .COPY_ADDRESS_REG(xa),
    .ALT_COPY_ADDRESS_REG(xalt), .XFLAGS(xf), .MAIN_BASE_ADDRESS(mba), .EXT_BASE_ADDRESS(eba),
    .EXT_FIELD_LENGTH(efl), .MAIN_RD_REQ(rd_req), .MAIN_RD_ADDR(rd_addr), .MAIN_RD_VALID(rd_valid),
    .MAIN_RD_DATA(rd_data), .EXT_WR_REQ(wr_req), .EXT_WR_ADDR(wr_addr), .EXT_WR_DATA(wr_data),
    .EXT_WR_ACK(wr_ack), .DONE(done), .SEQ(seq), .WR_J(wj), .WR_J_DATA(wjd), .ILLEGAL(ill),
    .RANGE_ERR(rerr), .OUT_OF_RANGE(oor));
  bcx_mem_model pm (.clk(clk), .arst_n(arst_n), .dly(dly), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_data(rd_data), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_ack(wr_ack));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Issues one instruction, waits a bounded time for its completion pulse when wt is set, and returns on a rising edge.
  task automatic iss(input logic [8:0] op, input logic [1:0] par, input logic [17:0] k, input logic wt);
    int i;
    @(posedge clk);
    instr <= '{word: {op, 3'h1, k}, parcel: par};
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    i = 0;
    #1;
    while (wt && done !== 1'b1 && i < 300) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i == 300) begin
      miscompares++;
      complete_run();
    end
    res = {ill, oor, rerr};
    sq = seq;
    // Returning on the edge keeps every later drive of the caller on a rising edge.
    @(posedge clk);
  endtask
  task automatic br(input logic [8:0] op, input logic [59:0] x, input logic [17:0] i, input logic [17:0] j,
                    input logic e);
    xj <= x;
    bi <= i;
    bj <= j;
    iss(op, 2'h1, 18'h2a5a5, 1'b1);
    `CHK(sq.jump, e)
    `CHK(sq.flush, e)
    `CHK(sq.target, 18'h2a5a5)
  endtask
  task automatic cpy(input logic [17:0] k, input int cnt, input logic [29:0] da, input logic [20:0] sa,
                     input logic z);
    int n0;
    int r0;
    n0 = pm.n;
    r0 = pm.nr;
    iss(bcx_pkg::OP_COPY, 2'h0, k, 1'b1);
    `CHK(res, 3'h0)
    `CHK(pm.n - n0, cnt)
    `CHK(pm.nr - r0, z ? 0 : cnt)
    `CHK({sq.next_parcel2, sq.next_word}, z ? 2'h2 : 2'h1)
    for (int w = 0; w < cnt; w++) begin
      `CHK(pm.wa[n0 + w], 30'(da + w))
      `CHK(pm.wd[n0 + w], z ? 60'h0 : {39'h5a5a5a5a5a, 21'(sa + w)})
    end
  endtask
  task automatic cerr(input logic [1:0] par, input logic [17:0] k, input logic [2:0] e);
    iss(bcx_pkg::OP_COPY, par, k, 1'b1);
    `CHK(res, e)
  endtask
  initial begin
    issue = 1'b0;
    abort = 1'b0;
    instr = '0;
    bi = 18'h0;
    bj = 18'h0;
    xj = 60'h0;
    xa = 60'h0;
    xalt = 18'h20;
    xf = 3'h1;
    mba = 21'h1000;
    eba = 30'h100;
    efl = 30'h3fffffff;
    dly = 2'h3;
    arst_n = 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    br(bcx_pkg::OP_ZERO_BR, 60'h0, 18'h0, 18'h0, 1'b1);
    br(bcx_pkg::OP_ZERO_BR, 60'hfffffffffffffff, 18'h0, 18'h0, 1'b1);
    br(bcx_pkg::OP_ZERO_BR, 60'h1, 18'h0, 18'h0, 1'b0);
    br(bcx_pkg::OP_PLUS_BR, 60'h7ffffffffffffff, 18'h0, 18'h0, 1'b1);
    br(bcx_pkg::OP_PLUS_BR, 60'h800000000000000, 18'h0, 18'h0, 1'b0);
    br(bcx_pkg::OP_DEF_BR, {12'h3ff, 48'h123}, 18'h0, 18'h0, 1'b0);
    br(bcx_pkg::OP_DEF_BR, {12'h3fe, 48'h0}, 18'h0, 18'h0, 1'b1);
    br(bcx_pkg::OP_INDEF_BR, {12'hc00, 48'hfff}, 18'h0, 18'h0, 1'b1);
    br(bcx_pkg::OP_INDEF_BR, {12'h400, 48'h0}, 18'h0, 18'h0, 1'b0);
    br(bcx_pkg::OP_EQ_BR, 60'h0, 18'h155, 18'h155, 1'b1);
    br(bcx_pkg::OP_EQ_BR, 60'h0, 18'h155, 18'h154, 1'b0);
    bi <= 18'h3fffe;
    iss({bcx_pkg::OP_CJUMP, 3'h0}, 2'h2, 18'h5, 1'b1);
    `CHK(sq.target, 18'h4)
    `CHK({sq.jump, sq.flush}, 2'h3)
    iss(bcx_pkg::OP_READ_CNT, 2'h3, 18'h3ffff, 1'b1);
    c0 = wjd;
    `CHK(wjd[59:48], 12'h0)
    iss(bcx_pkg::OP_READ_CNT, 2'h0, 18'h0, 1'b1);
    `CHK(wjd - c0, 60'h3)
    $display("branch and counter tests done");
    xa <= {36'habc123, 24'h000010};
    bj <= 18'h2;
    iss(bcx_pkg::OP_COPY, 2'h0, 18'h1, 1'b0);
    repeat (4) @(posedge clk);
    abort <= 1'b1;
    @(posedge clk);
    abort <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(busy, 1'b0)
    cpy(18'h1, 3, 30'h110, 21'h1020, 1'b0);
    xf <= 3'h7;
    dly <= 2'h0;
    xa <= {9'h0, 21'h40, 1'b0, 29'h0800020};
    bj <= 18'h3fffe;
    cpy(18'h3, 2, 30'h800120, 21'h1040, 1'b0);
    xf <= 3'h1;
    eba <= 30'h200000;
    xa <= 60'h5;
    bj <= 18'h0;
    cpy(18'h1, 1, 30'h200005, 21'h0, 1'b1);
    eba <= 30'h100;
    bj <= 18'h5;
    cpy(18'h3fffa, 0, 30'h0, 21'h0, 1'b0);
    $display("copy transfer tests done");
    cerr(2'h1, 18'h1, 3'h4);
    xf <= 3'h0;
    cerr(2'h0, 18'h1, 3'h4);
    xf <= 3'h1;
    efl <= 30'h800005;
    bj <= 18'h0;
    cerr(2'h0, 18'h1, 3'h2);
    xa <= 60'h4;
    cerr(2'h0, 18'h0, 3'h0);
    xf <= 3'h3;
    efl <= 30'h20000008;
    xa <= 60'h8;
    cerr(2'h0, 18'h1, 3'h2);
    xf <= 3'h1;
    efl <= 30'h3fffffff;
    bj <= 18'h3fffd;
    cerr(2'h0, 18'h1, 3'h1);
    $display("copy error tests done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
